// ==== src/mbsr_cfg.svh ====
/*
  constants of the bank-zero special register file: offsets, implemented-bit
  masks, reset values and bit positions. assumes a 7-bit direct address.
*/
`ifndef MBSR_CFG_SVH
`define MBSR_CFG_SVH
`define MBSR_OFF_WINDOW   7'h00
`define MBSR_OFF_T0COUNT  7'h01
`define MBSR_OFF_PCLOW    7'h02
`define MBSR_OFF_STAT     7'h03
`define MBSR_OFF_POINTER  7'h04
`define MBSR_OFF_PORT1    7'h05
`define MBSR_OFF_PORT2    7'h06
`define MBSR_OFF_PORT3    7'h07
`define MBSR_OFF_UPPER    7'h0A
`define MBSR_OFF_IRQCTL   7'h0B
`define MBSR_OFF_PIRQ     7'h0C
`define MBSR_OFF_T1LOW    7'h0E
`define MBSR_OFF_T1HIGH   7'h0F
`define MBSR_OFF_T1CTL    7'h10
`define MBSR_OFF_T2COUNT  7'h11
`define MBSR_OFF_T2CTL    7'h12
`define MBSR_OFF_SERBUF   7'h13
`define MBSR_OFF_SERCTL   7'h14
`define MBSR_OFF_CCLOW    7'h15
`define MBSR_OFF_CCHIGH   7'h16
`define MBSR_OFF_CCCTL    7'h17
`define MBSR_SFR_LIMIT    7'h20
`define MBSR_GPR_DEPTH    96
`define MBSR_MASK_ALL     8'hFF
`define MBSR_MASK_NONE    8'h00
`define MBSR_MASK_PORT1   8'h3F
`define MBSR_MASK_UPPER   8'h1F
`define MBSR_MASK_PIRQ    8'hCF
`define MBSR_MASK_T1CTL   8'h3F
`define MBSR_MASK_T2CTL   8'h7F
`define MBSR_MASK_CCCTL   8'h3F
`define MBSR_WMASK_STAT   8'hE7
`define MBSR_KEEP_STAT    8'h07
`define MBSR_KEEP_IRQCTL  8'h01
`define MBSR_POR_STAT     8'h18
`define MBSR_POR_ZERO     8'h00
`define MBSR_BIT_RP0      5
`define MBSR_BIT_TIMEOUT  4
`define MBSR_BIT_PWRDOWN  3
`endif

// ==== src/mbsr_pkg.sv ====
/*
  types of the bank-zero special register file.
  assumes mbsr_cfg.svh holds the numeric constants.
*/
package mbsr_pkg;
  typedef logic [7:0]  mbsr_byte_t;
  typedef logic [6:0]  mbsr_off_t;
  typedef logic [12:0] mbsr_pc_t;
  typedef enum logic [2:0] {
    mbsr_rst_none = 3'b001,
    mbsr_rst_pin  = 3'b010,
    mbsr_rst_wdt  = 3'b100
  } mbsr_rst_t;
endpackage

// ==== src/mbsr_bank0.sv ====
/*
  bank-zero special function register file with program counter and a small
  general purpose data memory behind the indirect window.
  assumes a core that issues one synchronous read or write per clock, and
  reset request inputs already synchronous to clock.
*/
// Summary of operation
// - Core registers answer at the same location whichever data bank is selected.
// - The program counter upper bits have no direct read or write path.
// - The 5-bit upper buffer is copied into counter bits 12:8 when the counter low byte is written.
// - Power-on reset loads power-on values, pin and watchdog resets load the other-reset values.
// - Unknown bits come up as a fixed value, unchanged bits keep their value, conditional bits follow the cause.
// - Unimplemented addresses and bits read zero and ignore writes.
// - Port writes go to the output latch while port reads return the pin levels.
`timescale 1ns/100ps
`include "mbsr_cfg.svh"
module mbsr_bank0 (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 external_reset_pin,
  input  wire logic                 wdt_timeout,
  input  wire logic                 core_asleep,
  input  wire mbsr_pkg::mbsr_off_t  mem_addr,
  input  wire logic                 mem_rd_en,
  input  wire logic                 mem_wr_en,
  input  wire mbsr_pkg::mbsr_byte_t mem_wr_data,
  output mbsr_pkg::mbsr_byte_t      mem_rd_data,
  input  wire logic                 pc_advance,
  input  wire logic                 alu_flags_we,
  input  wire logic [2:0]           alu_flags,
  input  wire logic [2:0]           irq_ctl_events,
  input  wire logic [3:0]           pirq_events,
  input  wire logic [5:0]           io_port_first_pins,
  input  wire logic [7:0]           io_port_second_pins,
  input  wire logic [7:0]           io_port_third_pins,
  output logic [5:0]                io_port_first_latch,
  output logic [7:0]                io_port_second_latch,
  output logic [7:0]                io_port_third_latch,
  output mbsr_pkg::mbsr_pc_t        prog_counter,
  output mbsr_pkg::mbsr_byte_t      core_status,
  output mbsr_pkg::mbsr_byte_t      interrupt_control,
  output mbsr_pkg::mbsr_byte_t      peripheral_irq_flags,
  output mbsr_pkg::mbsr_byte_t      timer_zero_count,
  output logic [15:0]               timer_one_count,
  output mbsr_pkg::mbsr_byte_t      timer_one_control,
  output mbsr_pkg::mbsr_byte_t      timer_two_count,
  output mbsr_pkg::mbsr_byte_t      timer_two_control,
  output mbsr_pkg::mbsr_byte_t      serial_port_buffer,
  output mbsr_pkg::mbsr_byte_t      serial_port_control,
  output logic [15:0]               capture_compare_value,
  output mbsr_pkg::mbsr_byte_t      capture_compare_control
);
  import mbsr_pkg::*;

  mbsr_byte_t sfr_q [0:31];
  mbsr_byte_t sfr_d [0:31];
  mbsr_byte_t gpr_q [0:`MBSR_GPR_DEPTH-1];
  mbsr_pc_t   pc_q;
  mbsr_pc_t   pc_d;
  mbsr_byte_t rd_data_q;
  mbsr_byte_t rd_data_d;
  logic       gpr_we;
  logic [6:0] gpr_idx;
  logic [7:0] eff_addr;
  logic       sfr_hit;
  logic       gpr_hit;
  logic       pcl_wr;
  logic       other_rst;
  mbsr_rst_t  rst_cause;

  function automatic logic [4:0] sidx(input mbsr_off_t o);
    return o[4:0];
  endfunction

  // core locations are decoded without the bank bit
  function automatic logic is_core(input mbsr_off_t o);
    return (o == `MBSR_OFF_WINDOW) || (o == `MBSR_OFF_PCLOW) || (o == `MBSR_OFF_STAT) ||
           (o == `MBSR_OFF_POINTER) || (o == `MBSR_OFF_UPPER) || (o == `MBSR_OFF_IRQCTL);
  endfunction

  // window and counter low byte have no storage in the array
  function automatic mbsr_byte_t impl_mask(input mbsr_off_t o);
    if (o == `MBSR_OFF_WINDOW || o == `MBSR_OFF_PCLOW) begin
      return `MBSR_MASK_NONE;
    end else if (o == `MBSR_OFF_PORT1) begin
      return `MBSR_MASK_PORT1;
    end else if (o == `MBSR_OFF_UPPER) begin
      return `MBSR_MASK_UPPER;
    end else if (o == `MBSR_OFF_PIRQ) begin
      return `MBSR_MASK_PIRQ;
    end else if (o == `MBSR_OFF_T1CTL) begin
      return `MBSR_MASK_T1CTL;
    end else if (o == `MBSR_OFF_T2CTL) begin
      return `MBSR_MASK_T2CTL;
    end else if (o == `MBSR_OFF_CCCTL) begin
      return `MBSR_MASK_CCCTL;
    end else if (o == 7'h08 || o == 7'h09 || o == 7'h0D || o >= 7'h18) begin
      return `MBSR_MASK_NONE;
    end else begin
      return `MBSR_MASK_ALL;
    end
  endfunction

  // bits that survive a pin or watchdog reset
  function automatic mbsr_byte_t keep_mask(input mbsr_off_t o);
    if (o == `MBSR_OFF_STAT) begin
      return `MBSR_KEEP_STAT;
    end else if (o == `MBSR_OFF_IRQCTL) begin
      return `MBSR_KEEP_IRQCTL;
    end else if (o == `MBSR_OFF_T1CTL) begin
      return `MBSR_MASK_T1CTL;
    end else if (o == `MBSR_OFF_T0COUNT || o == `MBSR_OFF_POINTER || o == `MBSR_OFF_PORT1 ||
                 o == `MBSR_OFF_PORT2 || o == `MBSR_OFF_PORT3 || o == `MBSR_OFF_T1LOW ||
                 o == `MBSR_OFF_T1HIGH || o == `MBSR_OFF_SERBUF || o == `MBSR_OFF_CCLOW ||
                 o == `MBSR_OFF_CCHIGH) begin
      return impl_mask(o);
    end else begin
      return `MBSR_MASK_NONE;
    end
  endfunction

  assign other_rst = external_reset_pin | wdt_timeout;
  assign rst_cause = wdt_timeout ? mbsr_rst_wdt : (external_reset_pin ? mbsr_rst_pin : mbsr_rst_none);

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      sfr_d[i] = sfr_q[i];
    end
    pc_d      = pc_q;
    rd_data_d = rd_data_q;
    pcl_wr    = 1'b0;
    gpr_we    = 1'b0;
    // window redirects through the pointer, otherwise the bank bit joins the address
    if (mem_addr == `MBSR_OFF_WINDOW) begin
      eff_addr = sfr_q[sidx(`MBSR_OFF_POINTER)];
    end else begin
      eff_addr = {sfr_q[sidx(`MBSR_OFF_STAT)][`MBSR_BIT_RP0], mem_addr};
    end
    // bank one peripheral registers live elsewhere and read zero here
    sfr_hit = is_core(eff_addr[6:0]) || (!eff_addr[7] && eff_addr[6:0] < `MBSR_SFR_LIMIT);
    gpr_hit = !eff_addr[7] && eff_addr[6:0] >= `MBSR_SFR_LIMIT;
    gpr_idx = 7'(eff_addr[6:0] - `MBSR_SFR_LIMIT);
    if (other_rst) begin
      for (int i = 0; i < 32; i++) begin
        sfr_d[i] = sfr_q[i] & keep_mask(7'(i));
      end
      sfr_d[sidx(`MBSR_OFF_STAT)][`MBSR_BIT_TIMEOUT] = (rst_cause != mbsr_rst_wdt);
      sfr_d[sidx(`MBSR_OFF_STAT)][`MBSR_BIT_PWRDOWN] = !core_asleep;
      pc_d = '0;
    end else begin
      if (pc_advance) begin
        pc_d = 13'(pc_q + 13'h0001);
      end
      if (mem_wr_en && sfr_hit) begin
        if (eff_addr[6:0] == `MBSR_OFF_PCLOW) begin
          pcl_wr = 1'b1;
          // only write path into the upper bits goes through the buffer
          pc_d = {sfr_q[sidx(`MBSR_OFF_UPPER)][4:0], mem_wr_data};
        end else if (eff_addr[6:0] == `MBSR_OFF_STAT) begin
          sfr_d[sidx(`MBSR_OFF_STAT)] = (sfr_q[sidx(`MBSR_OFF_STAT)] & ~`MBSR_WMASK_STAT) |
                                        (mem_wr_data & `MBSR_WMASK_STAT);
        end else begin
          sfr_d[sidx(eff_addr[6:0])] = (sfr_q[sidx(eff_addr[6:0])] & ~impl_mask(eff_addr[6:0])) |
                                       (mem_wr_data & impl_mask(eff_addr[6:0]));
        end
      end else if (mem_wr_en && gpr_hit) begin
        gpr_we = 1'b1;
      end
      // hardware events win over a software clear in the same cycle
      sfr_d[sidx(`MBSR_OFF_PIRQ)][3:0]   = sfr_d[sidx(`MBSR_OFF_PIRQ)][3:0] | pirq_events;
      sfr_d[sidx(`MBSR_OFF_IRQCTL)][2:0] = sfr_d[sidx(`MBSR_OFF_IRQCTL)][2:0] | irq_ctl_events;
      if (alu_flags_we) begin
        sfr_d[sidx(`MBSR_OFF_STAT)][2:0] = alu_flags;
      end
    end
    if (mem_rd_en) begin
      if (sfr_hit && eff_addr[6:0] == `MBSR_OFF_PCLOW) begin
        rd_data_d = pc_q[7:0];
      end else if (sfr_hit && eff_addr[6:0] == `MBSR_OFF_PORT1) begin
        rd_data_d = {2'b00, io_port_first_pins};
      end else if (sfr_hit && eff_addr[6:0] == `MBSR_OFF_PORT2) begin
        rd_data_d = io_port_second_pins;
      end else if (sfr_hit && eff_addr[6:0] == `MBSR_OFF_PORT3) begin
        rd_data_d = io_port_third_pins;
      end else if (sfr_hit) begin
        rd_data_d = sfr_q[sidx(eff_addr[6:0])] & impl_mask(eff_addr[6:0]);
      end else if (gpr_hit) begin
        rd_data_d = gpr_q[gpr_idx];
      end else begin
        rd_data_d = 8'h00;
      end
    end
  end

  // unknown bits come up as zero after power-on
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        sfr_q[i] <= (i == 3) ? `MBSR_POR_STAT : `MBSR_POR_ZERO;
      end
      pc_q      <= '0;
      rd_data_q <= 8'h00;
    end else begin
      for (int i = 0; i < 32; i++) begin
        sfr_q[i] <= sfr_d[i];
      end
      pc_q      <= pc_d;
      rd_data_q <= rd_data_d;
    end
  end

  // data memory is left unreset, contents are unknown by nature
  always_ff @(posedge clock) begin
    if (gpr_we) begin
      gpr_q[gpr_idx] <= mem_wr_data;
    end
  end

  assign mem_rd_data             = rd_data_q;
  assign prog_counter            = pc_q;
  assign io_port_first_latch     = sfr_q[sidx(`MBSR_OFF_PORT1)][5:0];
  assign io_port_second_latch    = sfr_q[sidx(`MBSR_OFF_PORT2)];
  assign io_port_third_latch     = sfr_q[sidx(`MBSR_OFF_PORT3)];
  assign core_status             = sfr_q[sidx(`MBSR_OFF_STAT)];
  assign interrupt_control       = sfr_q[sidx(`MBSR_OFF_IRQCTL)];
  assign peripheral_irq_flags    = sfr_q[sidx(`MBSR_OFF_PIRQ)];
  assign timer_zero_count        = sfr_q[sidx(`MBSR_OFF_T0COUNT)];
  assign timer_one_count         = {sfr_q[sidx(`MBSR_OFF_T1HIGH)], sfr_q[sidx(`MBSR_OFF_T1LOW)]};
  assign timer_one_control       = sfr_q[sidx(`MBSR_OFF_T1CTL)];
  assign timer_two_count         = sfr_q[sidx(`MBSR_OFF_T2COUNT)];
  assign timer_two_control       = sfr_q[sidx(`MBSR_OFF_T2CTL)];
  assign serial_port_buffer      = sfr_q[sidx(`MBSR_OFF_SERBUF)];
  assign serial_port_control     = sfr_q[sidx(`MBSR_OFF_SERCTL)];
  assign capture_compare_value   = {sfr_q[sidx(`MBSR_OFF_CCHIGH)], sfr_q[sidx(`MBSR_OFF_CCLOW)]};
  assign capture_compare_control = sfr_q[sidx(`MBSR_OFF_CCCTL)];

  default clocking mbsr_cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  core_mirror_a: assert property (mem_wr_en && mem_addr == `MBSR_OFF_UPPER && !other_rst |=>
    sfr_q[sidx(`MBSR_OFF_UPPER)] == {3'b000, $past(mem_wr_data[4:0])})
    else $error("upper buffer write lost");
  no_direct_upper_a: assert property ($changed(pc_q[12:8]) |->
    $past(pcl_wr || pc_advance || other_rst))
    else $error("counter upper bits changed without cause");
  pcl_load_a: assert property (pcl_wr |=>
    pc_q == {$past(sfr_q[sidx(`MBSR_OFF_UPPER)][4:0]), $past(mem_wr_data)})
    else $error("counter load from buffer wrong");
  other_reset_a: assert property (other_rst |=> pc_q == 13'h0000 &&
    sfr_q[sidx(`MBSR_OFF_UPPER)] == 8'h00 && core_status[7:5] == 3'b000 &&
    core_status[`MBSR_BIT_TIMEOUT] == !$past(wdt_timeout))
    else $error("other reset values wrong");
  keep_value_a: assert property (other_rst |=>
    $stable(sfr_q[sidx(`MBSR_OFF_POINTER)]) && $stable(core_status[2:0]))
    else $error("unchanged bits altered by reset");
  unimpl_zero_a: assert property (mem_rd_en && (mem_addr == 7'h08 || mem_addr == `MBSR_OFF_UPPER) |=>
    mem_rd_data[7:5] == 3'b000)
    else $error("unimplemented bits read nonzero");
  // bank-one peripherals are absent here, so port reads count only in bank zero
  port_pins_a: assert property (mem_rd_en && mem_addr == `MBSR_OFF_PORT2 && !core_status[`MBSR_BIT_RP0] |=>
    mem_rd_data == $past(io_port_second_pins))
    else $error("port read not from pins");
  indirect_a: assert property ((mem_wr_en && mem_addr == `MBSR_OFF_WINDOW && !other_rst &&
    sfr_q[sidx(`MBSR_OFF_POINTER)] >= 8'h20 && sfr_q[sidx(`MBSR_OFF_POINTER)] < 8'h80) ##1 !mem_wr_en ##1
    (mem_rd_en && mem_addr == `MBSR_OFF_WINDOW && $stable(sfr_q[sidx(`MBSR_OFF_POINTER)])) |=>
    mem_rd_data == $past(mem_wr_data, 3))
    else $error("indirect access missed memory");
  flag_set_wins_a: assert property (pirq_events[0] && !other_rst |=> peripheral_irq_flags[0])
    else $error("event flag lost");
  port_latch_a: assert property (mem_wr_en && mem_addr == `MBSR_OFF_PORT3 && !other_rst &&
    !core_status[`MBSR_BIT_RP0] |=> io_port_third_latch == $past(mem_wr_data))
    else $error("port write missed the latch");
  reset_clear_a: assert property (other_rst |=> peripheral_irq_flags == 8'h00 &&
    timer_two_count == 8'h00 && timer_two_control == 8'h00 &&
    serial_port_control == 8'h00 && capture_compare_control == 8'h00)
    else $error("cleared registers not zero after reset");
  reset_keep_a: assert property (other_rst |=> $stable(io_port_second_latch) &&
    $stable(timer_zero_count) && $stable(timer_one_count) && $stable(capture_compare_value))
    else $error("kept registers altered by reset");
  powerdown_bit_a: assert property (other_rst |=>
    core_status[`MBSR_BIT_PWRDOWN] == !$past(core_asleep))
    else $error("power-down bit wrong after reset");
  hole_read_a: assert property (mem_rd_en && mem_addr >= 7'h18 && mem_addr < `MBSR_SFR_LIMIT |=>
    mem_rd_data == 8'h00)
    else $error("unimplemented address read nonzero");
  status_mirror_a: assert property (mem_rd_en && mem_addr == `MBSR_OFF_STAT |=>
    mem_rd_data == $past(core_status))
    else $error("status read differs between banks");
  window_zero_a: assert property (mem_rd_en && mem_addr == `MBSR_OFF_WINDOW &&
    sfr_q[sidx(`MBSR_OFF_POINTER)] == 8'h00 |=> mem_rd_data == 8'h00)
    else $error("window read back stored data");

  bank_one_upper_c: cover property (mem_wr_en && mem_addr == `MBSR_OFF_UPPER && core_status[`MBSR_BIT_RP0]);
  pcl_load_c: cover property (pcl_wr && sfr_q[sidx(`MBSR_OFF_UPPER)] != 8'h00);
  wdt_reset_c: cover property (wdt_timeout);
  indirect_c: cover property (mem_rd_en && mem_addr == `MBSR_OFF_WINDOW && gpr_hit);
  set_wins_c: cover property (pirq_events[0] && mem_wr_en && mem_addr == `MBSR_OFF_PIRQ);
endmodule

// ==== testbench/test_mcu_bank0_special_registers.sv ====
/*
  self-checking bench for the bank-zero special register file.
  assumes mbsr_pkg and mbsr_cfg.svh from src/; the bench drives every port itself.
*/
`timescale 1ns/100ps
`include "mbsr_cfg.svh"
module test_mcu_bank0_special_registers;
  import mbsr_pkg::*;
  logic                clock;
  logic                reset_n;
  logic                external_reset_pin;
  logic                wdt_timeout;
  logic                core_asleep;
  mbsr_off_t           mem_addr;
  logic                mem_rd_en;
  logic                mem_wr_en;
  mbsr_byte_t          mem_wr_data;
  mbsr_byte_t          mem_rd_data;
  logic                pc_advance;
  logic                alu_flags_we;
  logic [2:0]          alu_flags;
  logic [2:0]          irq_ctl_events;
  logic [3:0]          pirq_events;
  logic [5:0]          p1_pins;
  logic [7:0]          p2_pins;
  logic [7:0]          p3_pins;
  logic [5:0]          p1_latch;
  logic [7:0]          p2_latch;
  logic [7:0]          p3_latch;
  mbsr_pc_t            prog_counter;
  mbsr_byte_t          core_status;
  mbsr_byte_t          interrupt_control;
  mbsr_byte_t          pirq_flags;
  mbsr_byte_t          t0_count;
  logic [15:0]         t1_count;
  mbsr_byte_t          t1_ctl;
  mbsr_byte_t          t2_count;
  mbsr_byte_t          t2_ctl;
  mbsr_byte_t          ser_buf;
  mbsr_byte_t          ser_ctl;
  logic [15:0]         cc_value;
  mbsr_byte_t          cc_ctl;
  int                  miscompares = 0;
  int                  num_checks = 0;

  mbsr_bank0 u_dut (.clock(clock), .reset_n(reset_n), .external_reset_pin(external_reset_pin),
    .wdt_timeout(wdt_timeout), .core_asleep(core_asleep), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
    .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data), .pc_advance(pc_advance),
    .alu_flags_we(alu_flags_we), .alu_flags(alu_flags), .irq_ctl_events(irq_ctl_events),
    .pirq_events(pirq_events), .io_port_first_pins(p1_pins), .io_port_second_pins(p2_pins),
    .io_port_third_pins(p3_pins), .io_port_first_latch(p1_latch), .io_port_second_latch(p2_latch),
    .io_port_third_latch(p3_latch), .prog_counter(prog_counter), .core_status(core_status),
    .interrupt_control(interrupt_control), .peripheral_irq_flags(pirq_flags), .timer_zero_count(t0_count),
    .timer_one_count(t1_count), .timer_one_control(t1_ctl), .timer_two_count(t2_count),
    .timer_two_control(t2_ctl), .serial_port_buffer(ser_buf), .serial_port_control(ser_ctl),
    .capture_compare_value(cc_value), .capture_compare_control(cc_ctl));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one access every other cycle so a strobe is never driven twice in one step
  task automatic wr(input mbsr_off_t a, input mbsr_byte_t d);
    @(posedge clock);
    mem_addr <= a;
    mem_wr_data <= d;
    mem_wr_en <= 1'b1;
    @(posedge clock);
    mem_wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input mbsr_off_t a, output mbsr_byte_t d);
    @(posedge clock);
    mem_addr <= a;
    mem_rd_en <= 1'b1;
    @(posedge clock);
    mem_rd_en <= 1'b0;
    #1 d = mem_rd_data;
  endtask

  task automatic rd_chk(input mbsr_off_t a, input mbsr_byte_t exp);
    mbsr_byte_t v;
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic pulse_reset(input logic from_wdt, input logic asleep);
    @(posedge clock);
    core_asleep <= asleep;
    if (from_wdt) wdt_timeout <= 1'b1;
    else external_reset_pin <= 1'b1;
    @(posedge clock);
    wdt_timeout <= 1'b0;
    external_reset_pin <= 1'b0;
    #1;
  endtask

  task automatic test_por_values;
    chk(core_status, 16'h0018);
    chk(prog_counter, 16'h0000);
    rd_chk(`MBSR_OFF_UPPER, 8'h00);
    rd_chk(`MBSR_OFF_STAT, 8'h18);
  endtask

  task automatic test_bank_mirror;
    wr(`MBSR_OFF_STAT, 8'h20);
    chk(core_status, 16'h0038);
    wr(`MBSR_OFF_UPPER, 8'h0C);
    rd_chk(`MBSR_OFF_UPPER, 8'h0C);
    rd_chk(`MBSR_OFF_STAT, 8'h38);
    // bank-one port address holds nothing in this block
    rd_chk(`MBSR_OFF_PORT2, 8'h00);
    wr(`MBSR_OFF_STAT, 8'h00);
    rd_chk(`MBSR_OFF_UPPER, 8'h0C);
  endtask

  task automatic test_counter_load;
    wr(`MBSR_OFF_UPPER, 8'hF5);
    rd_chk(`MBSR_OFF_UPPER, 8'h15);
    chk(prog_counter, 16'h0000);
    wr(`MBSR_OFF_PCLOW, 8'h34);
    chk(prog_counter, 16'h1534);
    @(posedge clock);
    pc_advance <= 1'b1;
    @(posedge clock);
    pc_advance <= 1'b0;
    rd_chk(`MBSR_OFF_PCLOW, 8'h35);
    // no address reaches the counter upper bits, a write near it must leave them alone
    wr(7'h09, 8'hFF);
    chk(prog_counter, 16'h1535);
  endtask

  task automatic test_unimplemented;
    mbsr_off_t holes [4] = '{7'h08, 7'h0D, 7'h18, 7'h1F};
    foreach (holes[i]) begin
      wr(holes[i], 8'hA5);
      rd_chk(holes[i], 8'h00);
    end
  endtask

  task automatic test_ports;
    wr(`MBSR_OFF_PORT1, 8'hFF);
    wr(`MBSR_OFF_PORT2, 8'hA5);
    wr(`MBSR_OFF_PORT3, 8'h5A);
    chk(p1_latch, 16'h003F);
    chk(p2_latch, 16'h00A5);
    chk(p3_latch, 16'h005A);
    rd_chk(`MBSR_OFF_PORT1, 8'h2C);
    rd_chk(`MBSR_OFF_PORT2, 8'h3C);
    rd_chk(`MBSR_OFF_PORT3, 8'hC3);
  endtask

  task automatic test_window;
    wr(`MBSR_OFF_POINTER, 8'h20);
    wr(`MBSR_OFF_WINDOW, 8'h77);
    rd_chk(7'h20, 8'h77);
    wr(`MBSR_OFF_POINTER, 8'h21);
    wr(7'h21, 8'h9B);
    rd_chk(`MBSR_OFF_WINDOW, 8'h9B);
    wr(`MBSR_OFF_WINDOW, 8'h4E);
    rd_chk(`MBSR_OFF_WINDOW, 8'h4E);
    wr(`MBSR_OFF_POINTER, 8'h00);
    rd_chk(`MBSR_OFF_WINDOW, 8'h00);
  endtask

  task automatic test_other_resets;
    wr(`MBSR_OFF_T0COUNT, 8'h5A);
    wr(`MBSR_OFF_T1LOW, 8'h11);
    wr(`MBSR_OFF_T1HIGH, 8'h22);
    wr(`MBSR_OFF_T1CTL, 8'hFF);
    wr(`MBSR_OFF_T2COUNT, 8'h33);
    wr(`MBSR_OFF_T2CTL, 8'hFF);
    wr(`MBSR_OFF_SERBUF, 8'h44);
    wr(`MBSR_OFF_SERCTL, 8'h55);
    wr(`MBSR_OFF_CCLOW, 8'h66);
    wr(`MBSR_OFF_CCHIGH, 8'h77);
    wr(`MBSR_OFF_CCCTL, 8'hFF);
    chk(t1_ctl, 16'h003F);
    chk(t2_ctl, 16'h007F);
    chk(cc_ctl, 16'h003F);
    chk(t2_count, 16'h0033);
    chk(ser_ctl, 16'h0055);
    @(posedge clock);
    alu_flags_we <= 1'b1;
    alu_flags <= 3'b101;
    irq_ctl_events <= 3'b011;
    pirq_events <= 4'h9;
    @(posedge clock);
    alu_flags_we <= 1'b0;
    irq_ctl_events <= 3'b000;
    pirq_events <= 4'h0;
    #1 chk(pirq_flags, 16'h0009);
    chk(interrupt_control, 16'h0003);
    // software clear of flag bits meets a fresh event in the same cycle
    @(posedge clock);
    mem_addr <= `MBSR_OFF_PIRQ;
    mem_wr_data <= 8'h02;
    mem_wr_en <= 1'b1;
    pirq_events <= 4'h1;
    @(posedge clock);
    mem_wr_en <= 1'b0;
    pirq_events <= 4'h0;
    #1 chk(pirq_flags, 16'h0003);
    pulse_reset(1'b0, 1'b0);
    chk(core_status, 16'h001D);
    chk(prog_counter, 16'h0000);
    chk(interrupt_control, 16'h0001);
    chk(pirq_flags, 16'h0000);
    chk(t0_count, 16'h005A);
    chk(t1_count, 16'h2211);
    chk(t1_ctl, 16'h003F);
    chk(t2_count, 16'h0000);
    chk(t2_ctl, 16'h0000);
    chk(ser_buf, 16'h0044);
    chk(ser_ctl, 16'h0000);
    chk(cc_value, 16'h7766);
    chk(cc_ctl, 16'h0000);
    rd_chk(`MBSR_OFF_UPPER, 8'h00);
    pulse_reset(1'b1, 1'b1);
    chk(core_status, 16'h0005);
    chk(p2_latch, 16'h00A5);
  endtask

  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    external_reset_pin = 1'b0;
    wdt_timeout = 1'b0;
    core_asleep = 1'b0;
    mem_addr = '0;
    mem_rd_en = 1'b0;
    mem_wr_en = 1'b0;
    mem_wr_data = '0;
    pc_advance = 1'b0;
    alu_flags_we = 1'b0;
    alu_flags = 3'b000;
    irq_ctl_events = 3'b000;
    pirq_events = 4'h0;
    p1_pins = 6'h2C;
    p2_pins = 8'h3C;
    p3_pins = 8'hC3;
    repeat (8) @(posedge clock);
    // brown-out status lives outside this bank and is never written here
    reset_n <= 1'b1;
    #1;
    test_por_values();
    test_bank_mirror();
    test_counter_load();
    test_unimplemented();
    test_ports();
    test_window();
    test_other_resets();
    stop_test();
  end
endmodule
